// >>> hw/lft_pkg.sv
package lft_pkg;

   // ***********************************************************************
   // Clock and timing figures.
   // ***********************************************************************
   localparam int unsigned CLK_HZ       = 200_000_000;
   localparam int unsigned TONE_HZ      = 22_000;
   localparam int unsigned EXT_LOW_NS   = 42_000;
   localparam int unsigned RETRY_MS     = 1_000;
   // Half period of the internal tone, rounded down.
   localparam int unsigned TONE_HALF_CYC = CLK_HZ / (2 * TONE_HZ);
   // Least low time of the external tone before it counts as stopped, rounded up.
   localparam int unsigned EXT_LOW_CYC  = (EXT_LOW_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int unsigned RETRY_CYC    = RETRY_MS * (CLK_HZ / 1000);

   // ***********************************************************************
   // Register map, byte addresses, one 32-bit word each.
   // ***********************************************************************
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;

   localparam int unsigned CTRL_OUT_EN_BIT   = 0;
   localparam int unsigned CTRL_RESTART_BIT  = 1;
   localparam int unsigned CTRL_TSRC_BIT     = 2;
   localparam int unsigned CTRL_SINK_BIT     = 3;
   localparam int unsigned CTRL_EPF_DLY_LSB  = 4;
   localparam int unsigned CTRL_WIDTH        = 6;
   localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 6'h00;

   localparam int unsigned STAT_THERMAL_BIT  = 0;
   localparam int unsigned STAT_TONE_BIT     = 1;
   localparam int unsigned STAT_EPF_BIT      = 2;
   localparam int unsigned STAT_OT_LIVE_BIT  = 3;
   localparam int unsigned STAT_SHUT_BIT     = 4;

   // Control fields in register order, bit 0 last.
   typedef struct packed {
      logic [1:0] epf_release_delay;  // Bits 5:4, b1 then b0.
      logic       reverse_sink_sel;
      logic       tone_source_sel;
      logic       restart_mode_sel;
      logic       out_enable;
   } lft_ctrl_s;

   // Thermal protection states; run to latch flips one bit, run to hiccup two.
   typedef enum logic [1:0] {
      TH_RUN    = 2'h0,
      TH_LATCH  = 2'h1,
      TH_HICCUP = 2'h3
   } lft_therm_e;

endpackage

// >>> hw/lft_tone_detect.sv
`timescale 1ns/10ps
// Measures the period of the squared tone input between rising edges and
// reports a tone once one period falls inside the accept window.
module lft_tone_detect #(
   parameter int unsigned PER_MIN_TX = 8727,
   parameter int unsigned PER_MAX_TX = 9455,
   parameter int unsigned PER_MIN_RX = 8182,
   parameter int unsigned PER_MAX_RX = 10000
) (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic sense,
   input  wire logic transmit,
   output logic      detected,
   output logic      tone_out
);

   // ***********************************************************************
   // Elaboration checks.
   // ***********************************************************************
   if (PER_MIN_TX > PER_MAX_TX || PER_MIN_RX > PER_MAX_RX || PER_MAX_RX > 65534) begin : g_bad
      $error("Tone window parameters out of range.");
   end

   logic [15:0] per_cnt_ff;
   logic        sense_d_ff;
   logic        det_ff;
   logic        tone_ff;

   // Window selection: narrow while transmitting, wider while receiving.
   wire  [15:0] win_min  = transmit ? 16'(PER_MIN_TX) : 16'(PER_MIN_RX);
   wire  [15:0] win_max  = transmit ? 16'(PER_MAX_TX) : 16'(PER_MAX_RX);
   wire         rise     = sense & ~sense_d_ff;
   wire         in_win   = (per_cnt_ff >= win_min) && (per_cnt_ff <= win_max);
   wire         too_long = per_cnt_ff > win_max;

   // Period counter restarts on each rising edge and stops above the window.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         per_cnt_ff <= 16'h0000;
         sense_d_ff <= 1'b0;
      end else begin
         sense_d_ff <= sense;
         if (rise) begin
            per_cnt_ff <= 16'h0001;
         end else if (!too_long) begin
            per_cnt_ff <= per_cnt_ff + 16'h0001;
         end
      end
   end

   // One good period sets the flag at the second edge, within 1.5 cycles.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         det_ff  <= 1'b0;
         tone_ff <= 1'b0;
      end else begin
         if (rise) begin
            det_ff <= in_win;
         end else if (too_long) begin
            det_ff <= 1'b0;
         end
         tone_ff <= det_ff & sense;
      end
   end

   assign detected = det_ff;
   assign tone_out = tone_ff;

endmodule

// >>> hw/lft_fault_tone_ctrl.sv
`timescale 1ns/10ps
// How it works
// - Over-temperature turns off channel output and boost until cooled below 145 C.
// - Auto-restart mode retries once per second; succeeds only if cooled.
// - Hiccup cycle repeats while hot, then normal operation resumes.
// - Latched mode keeps the output off after a thermal trip, no retry.
// - Latched mode: host bus write once cooled re-enables; device stays off until then.
// - Thermal trip pulls interrupt low; any bus read releases it.
// - Latched mode: read clears thermal flag only once cooled.
// - Auto mode: thermal flag clears when the output restarts.
// - Sleep pin low turns outputs off and resets control to defaults.
// - Reverse-sink select limits back-feed below 10 mA, else 25 mA pull-down.
// - Active tone raises pull-down to about 60 mA.
// - Internal source: 22 kHz tone gated by the tone gate pin.
// - External source: host supplies 22 kHz on the gate pin, reproduced.
// - External source: output returns to reference after 42 us low.
// - Detected tone on open-drain output; present flag set while tone.
// - Detector reports new tone within about 1.5 cycles.
// - Tight threshold and window while the tone gate pin is high, looser while it is low.
// - Early power fail sets its flag and pulls interrupt low.
// - After recovery the flag clears once the selected delay elapses.
// - Every control bit resets to 0.
module lft_fault_tone_ctrl #(
   parameter int unsigned RETRY_CYCLES  = lft_pkg::RETRY_CYC,
   parameter int unsigned EXT_LOW_CYCLES = lft_pkg::EXT_LOW_CYC,
   parameter int unsigned TONE_HALF     = lft_pkg::TONE_HALF_CYC,
   parameter int unsigned EPF_DLY0      = 1,
   parameter int unsigned EPF_DLY1      = 2_000_000,
   parameter int unsigned EPF_DLY2      = 4_000_000,
   parameter int unsigned EPF_DLY3      = 8_000_000,
   parameter int unsigned PER_MIN_TX    = 8727,
   parameter int unsigned PER_MAX_TX    = 9455,
   parameter int unsigned PER_MIN_RX    = 8182,
   parameter int unsigned PER_MAX_RX    = 10000
) (
   input  wire logic        MCLK,
   input  wire logic        RST,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   input  wire logic        OVER_TEMP,
   input  wire logic        SLEEP_N,
   input  wire logic        TONE_GATE_PIN,
   input  wire logic        TONE_SENSE_IN,
   input  wire logic        EARLY_POWER_FAIL_CMP,
   output logic             CHANNEL_OUTPUT_EN,
   output logic             BOOST_NODE_EN,
   output logic             TONE_DRIVE,
   output logic             PULLDOWN_HIGH,
   output logic             REVERSE_SINK_LIMIT,
   output logic             DETECT_THRESH_HIGH,
   output logic             TONE_DETECT_OUT_O,
   output logic             TONE_DETECT_OUT_OE_N,
   output logic             IRQ_N
);

   // ***********************************************************************
   // Elaboration checks.
   // ***********************************************************************
   if (RETRY_CYCLES < 2 || EXT_LOW_CYCLES - 1 > 65534 || TONE_HALF - 1 > 65535 || EPF_DLY0 < 1) begin : g_bad
      $error("Timing parameters must be at least one cycle.");
   end

   // ***********************************************************************
   // Pin synchronisers.
   // ***********************************************************************
   logic [4:0] sync1_ff;
   logic [4:0] sync2_ff;
   wire  [4:0] pins_raw = {EARLY_POWER_FAIL_CMP, TONE_SENSE_IN, TONE_GATE_PIN, SLEEP_N, OVER_TEMP};

   // Two flops per pin; the first stage feeds only the second.
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         sync1_ff <= 5'h00;
         sync2_ff <= 5'h00;
      end else begin
         sync1_ff <= pins_raw;
         sync2_ff <= sync1_ff;
      end
   end

   wire ot_s    = sync2_ff[0];
   wire awake_s = sync2_ff[1];
   wire gate_s  = sync2_ff[2];
   wire sense_s = sync2_ff[3];
   wire epf_s   = sync2_ff[4];

   // ***********************************************************************
   // APB slave.
   // ***********************************************************************
   lft_pkg::lft_ctrl_s ctrl_ff;
   logic [31:0]        rdata_ff;
   logic               err_ff;

   wire setup      = PSEL & ~PENABLE;
   wire access     = PSEL & PENABLE;
   wire hit_ctrl   = PADDR == lft_pkg::ADDR_CTRL;
   wire hit_status = PADDR == lft_pkg::ADDR_STATUS;
   wire mapped     = hit_ctrl | hit_status;
   wire wr_any     = access & PWRITE;
   wire wr_ctrl    = wr_any & hit_ctrl;
   wire rd_any     = access & ~PWRITE;
   wire rd_status  = rd_any & hit_status;

   assign PREADY  = 1'b1;
   assign PRDATA  = rdata_ff;
   assign PSLVERR = access & err_ff;

   // Status word seen by software.
   logic       thermal_fault_ff;
   logic       early_power_fail_ff;
   logic       tone_present_flag;
   lft_pkg::lft_therm_e therm_ff;
   logic [31:0] status_word;

   always_comb begin
      status_word                                = 32'h0000_0000;
      status_word[lft_pkg::STAT_THERMAL_BIT]     = thermal_fault_ff;
      status_word[lft_pkg::STAT_TONE_BIT]        = tone_present_flag;
      status_word[lft_pkg::STAT_EPF_BIT]         = early_power_fail_ff;
      status_word[lft_pkg::STAT_OT_LIVE_BIT]     = ot_s;
      status_word[lft_pkg::STAT_SHUT_BIT]        = therm_ff != lft_pkg::TH_RUN;
   end

   wire [31:0] ctrl_word = {{(32 - lft_pkg::CTRL_WIDTH){1'b0}}, ctrl_ff};
   wire [31:0] nxt_rdata = hit_ctrl ? ctrl_word : (hit_status ? status_word : 32'h0000_0000);

   // Read data and error are captured in the setup cycle.
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         rdata_ff <= 32'h0000_0000;
         err_ff   <= 1'b0;
      end else if (setup) begin
         rdata_ff <= PWRITE ? 32'h0000_0000 : nxt_rdata;
         err_ff   <= ~mapped;
      end
   end

   // Control register; sleep returns it to defaults.
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         ctrl_ff <= lft_pkg::CTRL_RESET;
      end else if (!awake_s) begin
         ctrl_ff <= lft_pkg::CTRL_RESET;
      end else if (wr_ctrl) begin
         ctrl_ff <= PWDATA[lft_pkg::CTRL_WIDTH-1:0];
      end
   end

   // ***********************************************************************
   // Thermal protection.
   // ***********************************************************************
   logic [31:0]         retry_cnt_ff;
   lft_pkg::lft_therm_e nxt_therm;
   logic                restart_ok;
   logic                trip;

   wire retry_due = retry_cnt_ff == 32'(RETRY_CYCLES - 1);

   // State transitions for trip, retry and latched re-enable.
   always_comb begin
      nxt_therm  = therm_ff;
      restart_ok = 1'b0;
      trip       = 1'b0;
      unique case (therm_ff)
         lft_pkg::TH_RUN: begin
            if (ot_s) begin
               trip      = 1'b1;
               nxt_therm = ctrl_ff.restart_mode_sel ? lft_pkg::TH_HICCUP : lft_pkg::TH_LATCH;
            end
         end
         lft_pkg::TH_LATCH: begin
            if (wr_any && !ot_s) begin
               nxt_therm = lft_pkg::TH_RUN;
            end
         end
         lft_pkg::TH_HICCUP: begin
            if (retry_due && !ot_s) begin
               nxt_therm  = lft_pkg::TH_RUN;
               restart_ok = 1'b1;
            end
         end
         default: nxt_therm = lft_pkg::TH_RUN;
      endcase
   end

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         therm_ff <= lft_pkg::TH_RUN;
      end else if (!awake_s) begin
         therm_ff <= lft_pkg::TH_RUN;
      end else begin
         therm_ff <= nxt_therm;
      end
   end

   // One-second retry counter, restarted at shutdown and after each retry.
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         retry_cnt_ff <= 32'h0000_0000;
      end else if (therm_ff != lft_pkg::TH_HICCUP || retry_due) begin
         retry_cnt_ff <= 32'h0000_0000;
      end else begin
         retry_cnt_ff <= retry_cnt_ff + 32'h0000_0001;
      end
   end

   // Thermal flag: trip sets and wins over any clear in the same cycle.
   wire therm_clr = restart_ok
                  | (rd_status & ~ctrl_ff.restart_mode_sel & ~ot_s);

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         thermal_fault_ff <= 1'b0;
      end else if (trip) begin
         thermal_fault_ff <= 1'b1;
      end else if (therm_clr) begin
         thermal_fault_ff <= 1'b0;
      end
   end

   // ***********************************************************************
   // Early power fail.
   // ***********************************************************************
   logic [31:0] epf_cnt_ff;
   logic        epf_d_ff;
   logic [31:0] epf_dly;

   // Release delay chosen by the two-bit field.
   always_comb begin
      unique case (ctrl_ff.epf_release_delay)
         2'h0: epf_dly = 32'(EPF_DLY0);
         2'h1: epf_dly = 32'(EPF_DLY1);
         2'h2: epf_dly = 32'(EPF_DLY2);
         2'h3: epf_dly = 32'(EPF_DLY3);
      endcase
   end

   wire epf_rise = epf_s & ~epf_d_ff;
   wire epf_done = ~epf_s & (epf_cnt_ff >= epf_dly - 32'h0000_0001);

   // Flag sets while the comparator is high, counts the release delay after recovery.
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         early_power_fail_ff <= 1'b0;
         epf_cnt_ff          <= 32'h0000_0000;
         epf_d_ff            <= 1'b0;
      end else begin
         epf_d_ff <= epf_s;
         if (epf_s) begin
            early_power_fail_ff <= 1'b1;
            epf_cnt_ff          <= 32'h0000_0000;
         end else if (early_power_fail_ff) begin
            if (epf_done) begin
               early_power_fail_ff <= 1'b0;
               epf_cnt_ff          <= 32'h0000_0000;
            end else begin
               epf_cnt_ff <= epf_cnt_ff + 32'h0000_0001;
            end
         end
      end
   end

   // ***********************************************************************
   // Interrupt.
   // ***********************************************************************
   logic irq_ff;

   // Events set the request; any read releases it, a new event wins.
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         irq_ff <= 1'b0;
      end else if (trip || epf_rise) begin
         irq_ff <= 1'b1;
      end else if (rd_any) begin
         irq_ff <= 1'b0;
      end
   end

   assign IRQ_N = ~irq_ff;

   // ***********************************************************************
   // Tone generation.
   // ***********************************************************************
   logic [15:0] half_cnt_ff;
   logic        tone_sq_ff;
   logic [15:0] low_cnt_ff;
   logic        ext_active_ff;

   wire half_due = half_cnt_ff == 16'(TONE_HALF - 1);
   wire low_due  = low_cnt_ff >= 16'(EXT_LOW_CYCLES);

   // Free-running internal 22 kHz square wave.
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         half_cnt_ff <= 16'h0000;
         tone_sq_ff  <= 1'b0;
      end else if (half_due) begin
         half_cnt_ff <= 16'h0000;
         tone_sq_ff  <= ~tone_sq_ff;
      end else begin
         half_cnt_ff <= half_cnt_ff + 16'h0001;
      end
   end

   // External tone stays active until the gate pin has been low 42 us.
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         low_cnt_ff    <= 16'h0000;
         ext_active_ff <= 1'b0;
      end else if (gate_s) begin
         low_cnt_ff    <= 16'h0000;
         ext_active_ff <= 1'b1;
      end else if (low_due) begin
         ext_active_ff <= 1'b0;
      end else begin
         low_cnt_ff <= low_cnt_ff + 16'h0001;
      end
   end

   wire out_on      = awake_s & ctrl_ff.out_enable & (therm_ff == lft_pkg::TH_RUN);
   wire tone_active = ctrl_ff.tone_source_sel ? ext_active_ff : gate_s;
   wire nxt_drive   = ctrl_ff.tone_source_sel ? gate_s : (gate_s & tone_sq_ff);

   // ***********************************************************************
   // Tone detection.
   // ***********************************************************************
   logic det_tone;

   lft_tone_detect #(
      .PER_MIN_TX (PER_MIN_TX),
      .PER_MAX_TX (PER_MAX_TX),
      .PER_MIN_RX (PER_MIN_RX),
      .PER_MAX_RX (PER_MAX_RX)
   ) u_detect (
      .clk      (MCLK),
      .rst      (RST),
      .sense    (sense_s),
      .transmit (gate_s),
      .detected (tone_present_flag),
      .tone_out (det_tone)
   );

   // ***********************************************************************
   // Registered pin outputs.
   // ***********************************************************************
   logic [6:0] pins_ff;

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         pins_ff <= 7'h00;
      end else begin
         pins_ff[0] <= out_on;
         pins_ff[1] <= awake_s & (therm_ff == lft_pkg::TH_RUN);
         pins_ff[2] <= out_on & nxt_drive;
         pins_ff[3] <= out_on & tone_active;
         pins_ff[4] <= ctrl_ff.reverse_sink_sel;
         pins_ff[5] <= gate_s;
         pins_ff[6] <= det_tone;
      end
   end

   assign CHANNEL_OUTPUT_EN    = pins_ff[0];
   assign BOOST_NODE_EN        = pins_ff[1];
   assign TONE_DRIVE           = pins_ff[2];
   assign PULLDOWN_HIGH        = pins_ff[3];
   assign REVERSE_SINK_LIMIT   = pins_ff[4];
   assign DETECT_THRESH_HIGH   = pins_ff[5];
   // Open drain: drive low while the detected tone is low.
   assign TONE_DETECT_OUT_O    = 1'b0;
   assign TONE_DETECT_OUT_OE_N = pins_ff[6];

endmodule

// >>> test/lft_fault_tone_ctrl_asserts.sv
`timescale 1ns/10ps
// ********************
// Port checker for the fault and tone control block.
// ********************
module lft_asserts (
   input wire logic        MCLK,
   input wire logic        RST,
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic        PWRITE,
   input wire logic [7:0]  PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic        OVER_TEMP,
   input wire logic        SLEEP_N,
   input wire logic        TONE_GATE_PIN,
   input wire logic        EARLY_POWER_FAIL_CMP,
   input wire logic        CHANNEL_OUTPUT_EN,
   input wire logic        BOOST_NODE_EN,
   input wire logic        PULLDOWN_HIGH,
   input wire logic        REVERSE_SINK_LIMIT,
   input wire logic        DETECT_THRESH_HIGH,
   input wire logic        IRQ_N
);
   // All checks share the one clock and rest during reset.
   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (RST);

   // A trip turns output and boost off, and they stay off while hot.
   a_trip_off: assert property ($rose(OVER_TEMP) && CHANNEL_OUTPUT_EN |-> ##[1:4] !CHANNEL_OUTPUT_EN)
      else $error("Output still on after a trip.");
   a_hot_off: assert property (OVER_TEMP[*6] |-> !CHANNEL_OUTPUT_EN && !BOOST_NODE_EN)
      else $error("Output or boost on while hot.");
   // A power fail pulls the interrupt low; a quiet read releases it.
   a_epf_irq: assert property ($rose(EARLY_POWER_FAIL_CMP) |-> ##[1:4] !IRQ_N)
      else $error("No interrupt after a power fail.");
   a_read_release: assert property (
      (!OVER_TEMP && !EARLY_POWER_FAIL_CMP)[*4] ##0 (PSEL && PENABLE && !PWRITE) |=> IRQ_N)
      else $error("Interrupt held after a read.");
   // Sleep clears control; the sink bit reaches its pin.
   a_sleep_off: assert property ((!SLEEP_N)[*5] |-> !CHANNEL_OUTPUT_EN && !REVERSE_SINK_LIMIT)
      else $error("Output or sink on in sleep.");
   a_sink_select: assert property (
      SLEEP_N[*4] ##0 (PSEL && PENABLE && PWRITE && PADDR == lft_pkg::ADDR_CTRL
      && PWDATA[lft_pkg::CTRL_SINK_BIT]) |-> ##2 REVERSE_SINK_LIMIT)
      else $error("Sink limit not set.");
   // Tone gate: strong pull-down while sending, thresholds follow the pin.
   a_tone_pulldown: assert property ((TONE_GATE_PIN && CHANNEL_OUTPUT_EN)[*6] |-> PULLDOWN_HIGH)
      else $error("Weak pull-down during tone.");
   a_thresh_follow: assert property ($stable(TONE_GATE_PIN)[*5] |-> DETECT_THRESH_HIGH == TONE_GATE_PIN)
      else $error("Detector threshold does not follow gate.");
endmodule

bind lft_fault_tone_ctrl lft_asserts i_lft_asserts (
   .MCLK(MCLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
   .PWDATA(PWDATA), .OVER_TEMP(OVER_TEMP), .SLEEP_N(SLEEP_N), .TONE_GATE_PIN(TONE_GATE_PIN),
   .EARLY_POWER_FAIL_CMP(EARLY_POWER_FAIL_CMP), .CHANNEL_OUTPUT_EN(CHANNEL_OUTPUT_EN),
   .BOOST_NODE_EN(BOOST_NODE_EN), .PULLDOWN_HIGH(PULLDOWN_HIGH),
   .REVERSE_SINK_LIMIT(REVERSE_SINK_LIMIT), .DETECT_THRESH_HIGH(DETECT_THRESH_HIGH), .IRQ_N(IRQ_N));

// >>> test/lft_host_model.sv
`timescale 1ns/10ps
// ********************
// Host model: an APB master, one transfer at a time.
// ********************
module lft_host_model (
   input  wire logic        clk,
   output logic             psel = 1'b0,
   output logic             penable = 1'b0,
   output logic             pwrite = 1'b0,
   output logic [7:0]       paddr = 8'h00,
   output logic [31:0]      pwdata = 32'h0000_0000,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   // Setup, then access held until ready; any write once cool re-arms a latched shutdown.
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rv, output logic err);
      @(posedge clk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rv = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      paddr   <= ~a; // A released bus shows the inverse, not the last value.
      pwdata  <= ~wd;
   endtask
endmodule

// >>> test/lft_fault_tone_ctrl_tb_top.sv
`timescale 1ns/10ps
`define CHK(got, exp) \
   begin \
      n_tests++; \
      if ((got) !== (exp)) begin \
         errors++; \
         $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
      end \
   end
// ********************
// Bench: bus sequences and pin stimulus with expected values.
// ********************
module lft_fault_tone_ctrl_tb_top;
   logic        mclk, rst, ot, slp_n, gate, sense, early_power_fail, psel, pen, pwr, prdy, perr, e;
   logic        out_en, boost, drive, pd_hi, sink, thr, td_o, td_oe_n, irq_n;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, v;
   int          errors, n_tests, d;

   // Free-running 200 MHz clock.
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   // Block with shortened counts, and the host on its bus; windows and delays follow two bench figures.
   localparam int unsigned HALF = 5;
   localparam int unsigned DLY  = 10;
   lft_fault_tone_ctrl #(.RETRY_CYCLES(50), .EXT_LOW_CYCLES(20), .TONE_HALF(HALF),
      .EPF_DLY1(DLY), .EPF_DLY2(2 * DLY), .EPF_DLY3(4 * DLY), .PER_MIN_TX(2 * HALF - 1),
      .PER_MAX_TX(2 * HALF + 1), .PER_MIN_RX(2 * HALF - 2), .PER_MAX_RX(2 * HALF + 2)) i_lft_fault_tone_ctrl (
      .MCLK(mclk), .RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
      .PWDATA(pwdata), .PRDATA(prdata), .PREADY(prdy), .PSLVERR(perr), .OVER_TEMP(ot),
      .SLEEP_N(slp_n), .TONE_GATE_PIN(gate), .TONE_SENSE_IN(sense), .EARLY_POWER_FAIL_CMP(early_power_fail),
      .CHANNEL_OUTPUT_EN(out_en), .BOOST_NODE_EN(boost), .TONE_DRIVE(drive), .PULLDOWN_HIGH(pd_hi),
      .REVERSE_SINK_LIMIT(sink), .DETECT_THRESH_HIGH(thr), .TONE_DETECT_OUT_O(td_o),
      .TONE_DETECT_OUT_OE_N(td_oe_n), .IRQ_N(irq_n));
   lft_host_model i_lft_host_model (.clk(mclk), .psel(psel), .penable(pen), .pwrite(pwr),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(prdy), .pslverr(perr));

   // Cycle wait, control write and checked read.
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask
   task automatic wr(input logic [31:0] wd);
      i_lft_host_model.xfer(1'b1, lft_pkg::ADDR_CTRL, wd, v, e);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      i_lft_host_model.xfer(1'b0, a, 32'h0000_0000, v, e);
      `CHK(v, exp)
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // Cuts a hang short.
   initial begin
      #100_000;
      errors++;
      conclude();
   end

   // Main sequence.
   initial begin
      rst = 1'b1;
      {ot, slp_n, gate, sense, early_power_fail} = 5'h08;
      cyc(20);
      rst <= 1'b0;
      cyc(2);
      rd(lft_pkg::ADDR_CTRL, 32'h0000_0000);
      rd(8'h08, 32'h0000_0000);
      `CHK(e, 1'b1)
      // Latched shutdown, then re-enable by a write once cool.
      wr(32'h0000_0009);
      cyc(5);
      `CHK({out_en, boost, sink}, 3'h7)
      ot <= 1'b1;
      cyc(8);
      `CHK({out_en, boost, irq_n}, 3'h0)
      rd(lft_pkg::ADDR_STATUS, 32'h0000_0019);
      cyc(1);
      `CHK(irq_n, 1'b1)
      cyc(120);
      `CHK(out_en, 1'b0)
      ot <= 1'b0;
      cyc(8);
      `CHK(out_en, 1'b0)
      rd(lft_pkg::ADDR_STATUS, 32'h0000_0011);
      rd(lft_pkg::ADDR_STATUS, 32'h0000_0010);
      wr(32'h0000_000b);
      cyc(5);
      `CHK(out_en, 1'b1)
      // Auto restart: hiccup while hot, restart within one interval of cooling.
      ot <= 1'b1;
      cyc(130);
      `CHK(out_en, 1'b0)
      ot <= 1'b0;
      d = 0;
      while (out_en !== 1'b1 && d < 60) begin
         cyc(1);
         d++;
      end
      `CHK(out_en, 1'b1)
      rd(lft_pkg::ADDR_STATUS, 32'h0000_0000);
      // Internal tone: half period of five cycles while the gate is high.
      wr(32'h0000_0001);
      gate <= 1'b1;
      cyc(12);
      `CHK({pd_hi, thr}, 2'h3)
      v[0] = drive;
      cyc(5);
      `CHK(drive, ~v[0])
      gate <= 1'b0;
      cyc(12);
      `CHK({drive, pd_hi, thr}, 3'h0)
      // External tone: follows the gate, stops after the low time.
      wr(32'h0000_0005);
      gate <= 1'b1;
      cyc(5);
      `CHK(drive, 1'b1)
      gate <= 1'b0;
      cyc(12);
      `CHK({drive, pd_hi}, 2'h1)
      cyc(20);
      `CHK(pd_hi, 1'b0)
      // Detector windows: period 10 and 12 receive, 12 refused when sending.
      wr(32'h0000_0000);
      for (int k = 0; k < 3; k++) begin
         gate <= (k == 2);
         fork
            repeat (8) begin
               cyc(5 + (k > 0));
               sense <= 1'b1;
               cyc(5 + (k > 0));
               sense <= 1'b0;
            end
            begin
               cyc(26);
               rd(lft_pkg::ADDR_STATUS, {30'h0, k < 2, 1'b0});
               // The open-drain pin must be released at least once while a tone is reported.
               d = 0;
               repeat (12) begin
                  cyc(1);
                  d = d | td_oe_n;
               end
               `CHK(d[0], k < 2)
            end
         join
         cyc(40);
      end
      `CHK({td_o, td_oe_n}, 2'h0)
      // Power fail with each release delay.
      for (int k = 0; k < 4; k++) begin
         d = (k == 0) ? 1 : DLY << (k - 1);
         wr({26'h0, k[1:0], 4'h0});
         early_power_fail <= 1'b1;
         cyc(6);
         `CHK(irq_n, 1'b0)
         early_power_fail <= 1'b0;
         rd(lft_pkg::ADDR_STATUS, 32'h0000_0004);
         cyc(d / 2);
         if (d > 1) rd(lft_pkg::ADDR_STATUS, 32'h0000_0004);
         cyc(d + 8);
         rd(lft_pkg::ADDR_STATUS, 32'h0000_0000);
      end
      // Sleep clears control and turns the output off.
      wr(32'h0000_000b);
      slp_n <= 1'b0;
      cyc(6);
      `CHK({out_en, sink}, 2'h0)
      slp_n <= 1'b1;
      cyc(3);
      rd(lft_pkg::ADDR_CTRL, 32'h0000_0000);
      conclude();
   end
endmodule
